// file: hw/flyback_seq_consts.svh
// Constants for the flyback mode and fault sequencer.
// Assumes a 200 MHz system clock; all times become cycle counts here.
`ifndef FLYBACK_SEQ_CONSTS_SVH
`define FLYBACK_SEQ_CONSTS_SVH

// ==========================================================
// Clock and times
`define CLK_MHZ              200
`define SOFT_SHORT_MS        120
`define OVERSHOOT_HOLD_MS    500
`define MS_CYCLES            (`CLK_MHZ * 1000)
`define SOFT_SHORT_CYCLES    (`SOFT_SHORT_MS * `MS_CYCLES)
`define OVERSHOOT_CYCLES     (`OVERSHOOT_HOLD_MS * `MS_CYCLES)

// ==========================================================
// Frequencies and counts
`define ABS_MIN_FREQ_HZ      1000
`define RAISED_MIN_FREQ_HZ   4000
`define ABS_MIN_PERIOD       ((`CLK_MHZ * 1000000) / `ABS_MIN_FREQ_HZ)
`define RAISED_MIN_PERIOD    ((`CLK_MHZ * 1000000) / `RAISED_MIN_FREQ_HZ)
`define PROBE_CYCLES         3
`define LOCKOUT_SKIPS        3

`endif

// file: hw/flyback_seq_pkg.sv
// Types for the flyback mode and fault sequencer.
// Assumes the constants header is included by the modules.
package flyback_seq_pkg;
  // Top-level sequencer states
  typedef enum logic [2:0] {
    ST_START,
    ST_PROBE,
    ST_RUN,
    ST_WAIT,
    ST_FAULT,
    ST_LOCKOUT
  } seq_state_t;

  // Supply bias level select
  typedef enum logic [1:0] {
    BIAS_START,
    BIAS_RUN,
    BIAS_WAIT,
    BIAS_FAULT
  } bias_level_t;
endpackage

// file: hw/min_freq_if.sv
// Link between the sequencer and its minimum-frequency tracker.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface min_freq_if;
  logic cycle_start;
  logic cv_mode;
  logic high_load;
  logic above_reg;
  logic overshoot_10pct;
  logic raised_min;
  logic force_cycle;
  modport tracker (input cycle_start, cv_mode, high_load, above_reg, overshoot_10pct,
                   output raised_min, force_cycle);
  modport seq (output cycle_start, cv_mode, high_load, above_reg, overshoot_10pct,
               input raised_min, force_cycle);
endinterface
`default_nettype wire

// file: hw/min_freq_tracker.sv
// Dynamic minimum switching frequency tracker.
// Assumes the sequencer pulses cycle_start once per switching cycle.
`timescale 1ns/100ps
`default_nettype none
`include "flyback_seq_consts.svh"
module min_freq_tracker #(
  parameter int unsigned HOLD_CYCLES = `OVERSHOOT_CYCLES,
  parameter int unsigned RAISED_PER  = `RAISED_MIN_PERIOD,
  parameter int unsigned ABS_PER     = `ABS_MIN_PERIOD
) (
  input wire logic   clk,
  input wire logic   reset,
  min_freq_if.tracker mf
);
  typedef struct packed {
    logic        raised;
    logic [31:0] hold_cnt;
    logic [31:0] gap_cnt;
    logic        force_cycle;
  } trk_t;

  trk_t s_reg;
  trk_t s_next;

  // ==========================================================
  // Raised-minimum hold and gap timer
  always_comb
  begin
    s_next = s_reg;
    s_next.force_cycle = 1'b0;
    if (mf.high_load)
      s_next.raised = 1'b1;
    if (!mf.high_load && s_reg.raised)
    begin
      if (mf.overshoot_10pct || s_reg.hold_cnt >= HOLD_CYCLES - 1)
        s_next.raised = 1'b0;
    end
    // Saturate so a long stay above regulation cannot wrap the hold timer
    if (mf.above_reg && !mf.high_load)
    begin
      if (s_reg.hold_cnt < HOLD_CYCLES - 1)
        s_next.hold_cnt = s_reg.hold_cnt + 32'h1;
    end
    else
      s_next.hold_cnt = 32'h0;
    if (mf.cycle_start)
      s_next.gap_cnt = 32'h0;
    else if (s_reg.gap_cnt >= ((s_reg.raised || mf.cv_mode && mf.high_load) ? RAISED_PER : ABS_PER) - 1)
    begin
      s_next.gap_cnt = 32'h0;
      s_next.force_cycle = 1'b1;
    end
    else
      s_next.gap_cnt = s_reg.gap_cnt + 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign mf.raised_min  = s_reg.raised;
  assign mf.force_cycle = s_reg.force_cycle;

  property p_overshoot_clear;
    @(posedge clk) disable iff (reset)
      (s_reg.raised && !mf.high_load && mf.overshoot_10pct) |=> !s_reg.raised;
  endproperty
  a_overshoot_clear: assert property (p_overshoot_clear) else $error("raised floor kept after overshoot");

  property p_load_raise;
    @(posedge clk) disable iff (reset) mf.high_load |=> s_reg.raised;
  endproperty
  a_load_raise: assert property (p_load_raise) else $error("floor not raised under load");

  property p_gap_bound;
    @(posedge clk) disable iff (reset) (s_reg.raised && $past(s_reg.raised)) |-> s_reg.gap_cnt < RAISED_PER;
  endproperty
  a_gap_bound: assert property (p_gap_bound) else $error("gap exceeds floor");
endmodule
`default_nettype wire

// file: hw/flyback_seq.sv
// Mode and fault sequencer of an offline flyback controller.
// Assumes comparator inputs synchronous to CLK; one pulse per cycle.
`timescale 1ns/100ps
`default_nettype none
`include "flyback_seq_consts.svh"
module flyback_seq
  import flyback_seq_pkg::*;
#(
  parameter int unsigned SOFT_SHORT_CYC = `SOFT_SHORT_CYCLES,
  parameter int unsigned HOLD_CYC       = `OVERSHOOT_CYCLES
) (
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               RESET,
  // Supply comparators
  input  wire logic               SUPPLY_ABOVE_ON,
  input  wire logic               SUPPLY_BELOW_OFF,
  // Cycle events from the power stage
  input  wire logic               CYCLE_START,
  input  wire logic               DEMAG_DONE,
  input  wire logic               CYCLE_END,
  // Sense comparators
  input  wire logic               LINE_ABOVE_RUN,
  input  wire logic               OTHER_FAULT,
  input  wire logic               AUX_BELOW_SOFT_SHORT,
  input  wire logic               OUT_BELOW_REG,
  input  wire logic               OUT_ABOVE_REG,
  input  wire logic               OUT_OVERSHOOT_10PCT,
  input  wire logic               LOAD_AT_LIMIT,
  input  wire logic               PEAK_AT_CEILING,
  input  wire logic               HIGH_LOAD,
  input  wire logic               THERMAL_PIN_LOW,
  // Outputs
  output var  logic               GATE_ENABLE,
  output var  logic               PROBE_PEAK_CURRENT,
  output var  logic               FORCE_CYCLE,
  output var  logic               RAISED_MIN_FREQUENCY,
  output var  logic               CC_MODE,
  output var  logic               SOFT_SHORT_LATCH,
  output var  logic               SAMPLED_OUT_LOW,
  output var  flyback_seq_pkg::bias_level_t BIAS_LEVEL,
  output var  flyback_seq_pkg::seq_state_t  STATE
);
  import flyback_seq_pkg::*;

  typedef struct packed {
    seq_state_t  state;
    bias_level_t bias;
    logic        gate;
    logic        probe;
    logic [1:0]  probe_cnt;
    logic        cc;
    logic        sampled_low;
    logic        latch;
    logic [1:0]  skips;
    logic [31:0] ss_cnt;
    logic        force_o;
    logic        raised_o;
  } seq_t;

  seq_t s_reg;
  seq_t s_next;
  logic fault_now;

  min_freq_if mfi ();

  // ==========================================================
  // Minimum frequency tracker hookup
  // Gap timer held while stopped, so no cycle is forced in start, fault or lockout
  assign mfi.cycle_start     = CYCLE_START || !s_reg.gate;
  assign mfi.cv_mode         = !s_reg.cc;
  assign mfi.high_load       = HIGH_LOAD;
  assign mfi.above_reg       = OUT_ABOVE_REG;
  assign mfi.overshoot_10pct = OUT_OVERSHOOT_10PCT;

  min_freq_tracker #(
    .HOLD_CYCLES (HOLD_CYC),
    .RAISED_PER  (`RAISED_MIN_PERIOD),
    .ABS_PER     (`ABS_MIN_PERIOD)
  ) u_trk (
    .clk   (CLK),
    .reset (RESET),
    .mf    (mfi.tracker)
  );

  // Thermal pin acts as an external fault source
  // thermal pin fault
  assign fault_now = OTHER_FAULT || THERMAL_PIN_LOW;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    s_next = s_reg;
    s_next.force_o  = mfi.force_cycle;
    s_next.raised_o = mfi.raised_min;

    if (CYCLE_END)
      s_next.sampled_low = OUT_BELOW_REG;

    if (CYCLE_END)
      s_next.cc = OUT_BELOW_REG && LOAD_AT_LIMIT;

    if (!(s_reg.cc && AUX_BELOW_SOFT_SHORT) ||
        !(s_reg.state inside {ST_RUN, ST_WAIT}))
      s_next.ss_cnt = 32'h0;
    else if (s_reg.ss_cnt < SOFT_SHORT_CYC - 1)
      s_next.ss_cnt = s_reg.ss_cnt + 32'h1;

    unique case (s_reg.state)
      ST_START:
      begin
        s_next.gate = 1'b0;
        s_next.bias = BIAS_START;
        if (SUPPLY_ABOVE_ON)
        begin
          if (s_reg.latch && s_reg.skips != 2'(`LOCKOUT_SKIPS))
          begin
            s_next.skips = s_reg.skips + 2'h1;
            s_next.state = ST_LOCKOUT;
            s_next.bias  = BIAS_FAULT;
          end
          else
          begin
            s_next.latch     = 1'b0;
            s_next.skips     = 2'h0;
            s_next.state     = ST_PROBE;
            s_next.gate      = 1'b1;
            s_next.probe     = 1'b1;
            s_next.probe_cnt = 2'h0;
            s_next.cc        = 1'b0;
            s_next.bias      = BIAS_RUN;
          end
        end
      end
      ST_PROBE:
      begin
        if (fault_now || SUPPLY_BELOW_OFF)
        begin
          s_next.state = ST_FAULT;
          s_next.gate  = 1'b0;
          s_next.probe = 1'b0;
          s_next.bias  = BIAS_FAULT;
        end
        else if (CYCLE_END)
        begin
          if (s_reg.probe_cnt == 2'(`PROBE_CYCLES - 1))
          begin
            s_next.probe = 1'b0;
            if (LINE_ABOVE_RUN)
              s_next.state = ST_RUN;
            else
            begin
              s_next.state = ST_FAULT;
              s_next.gate  = 1'b0;
              s_next.bias  = BIAS_FAULT;
            end
          end
          else
            s_next.probe_cnt = s_reg.probe_cnt + 2'h1;
        end
      end
      ST_RUN, ST_WAIT:
      begin
        if (PEAK_AT_CEILING || s_reg.cc || CYCLE_START)
        begin
          s_next.state = ST_RUN;
          s_next.bias  = BIAS_RUN;
        end
        else if (DEMAG_DONE)
        begin
          s_next.state = ST_WAIT;
          s_next.bias  = BIAS_WAIT;
        end
        if (SUPPLY_BELOW_OFF)
        begin
          s_next.state = ST_START;
          s_next.gate  = 1'b0;
          s_next.bias  = BIAS_START;
        end
        else if (fault_now || s_reg.ss_cnt == SOFT_SHORT_CYC - 1)
        begin
          s_next.state = ST_FAULT;
          s_next.gate  = 1'b0;
          s_next.bias  = BIAS_FAULT;
          if (s_reg.ss_cnt == SOFT_SHORT_CYC - 1)
            s_next.latch = 1'b1;
        end
      end
      ST_FAULT, ST_LOCKOUT:
      begin
        s_next.gate = 1'b0;
        s_next.bias = BIAS_FAULT;
        if (SUPPLY_BELOW_OFF)
        begin
          s_next.state = ST_START;
          s_next.bias  = BIAS_START;
        end
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      s_reg       <= '0;
      s_reg.state <= ST_START;
      s_reg.bias  <= BIAS_START;
    end
    else
      s_reg <= s_next;
  end

  // Outputs come straight from the state register
  assign GATE_ENABLE          = s_reg.gate;
  assign PROBE_PEAK_CURRENT   = s_reg.probe;
  assign FORCE_CYCLE          = s_reg.force_o;
  assign RAISED_MIN_FREQUENCY = s_reg.raised_o;
  assign CC_MODE              = s_reg.cc;
  assign SOFT_SHORT_LATCH     = s_reg.latch;
  assign SAMPLED_OUT_LOW      = s_reg.sampled_low;
  assign BIAS_LEVEL           = s_reg.bias;
  assign STATE                = s_reg.state;

  // ==========================================================
  // Assertions
  // trip sets latch
  property p_ss_trip;
    @(posedge CLK) disable iff (RESET)
      (s_reg.state == ST_RUN && s_reg.ss_cnt == SOFT_SHORT_CYC - 1 && !SUPPLY_BELOW_OFF)
      |=> s_reg.latch && s_reg.state == ST_FAULT;
  endproperty
  a_ss_trip: assert property (p_ss_trip) else $error("soft-short not latched");

  property p_ss_restart;
    @(posedge CLK) disable iff (RESET) !AUX_BELOW_SOFT_SHORT |=> s_reg.ss_cnt == 32'h0;
  endproperty
  a_ss_restart: assert property (p_ss_restart) else $error("timer not restarted");

  property p_lockout_nogate;
    @(posedge CLK) disable iff (RESET) s_reg.state == ST_LOCKOUT |-> !s_reg.gate;
  endproperty
  a_lockout_nogate: assert property (p_lockout_nogate) else $error("switching in lockout");

  property p_start_nogate;
    @(posedge CLK) disable iff (RESET)
      (s_reg.state == ST_START && !SUPPLY_ABOVE_ON) |=> !s_reg.gate;
  endproperty
  a_start_nogate: assert property (p_start_nogate) else $error("switching below turn-on");

  property p_probe;
    @(posedge CLK) disable iff (RESET) s_reg.state == ST_PROBE |-> s_reg.probe && s_reg.gate;
  endproperty
  a_probe: assert property (p_probe) else $error("probe current missing");

  property p_ceiling_run;
    @(posedge CLK) disable iff (RESET)
      (s_reg.state == ST_RUN && PEAK_AT_CEILING && !fault_now && !SUPPLY_BELOW_OFF
       && s_reg.ss_cnt != SOFT_SHORT_CYC - 1) |=> s_reg.state == ST_RUN && s_reg.bias == BIAS_RUN;
  endproperty
  a_ceiling_run: assert property (p_ceiling_run) else $error("left run at ceiling");

  property p_fault_stop;
    @(posedge CLK) disable iff (RESET)
      (s_reg.state == ST_RUN && fault_now && !SUPPLY_BELOW_OFF)
      |=> !s_reg.gate && s_reg.bias == BIAS_FAULT;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("fault did not stop");

  property p_uvlo_stop;
    @(posedge CLK) disable iff (RESET)
      (s_reg.state == ST_WAIT && SUPPLY_BELOW_OFF) |=> s_reg.state == ST_START && s_reg.bias == BIAS_START;
  endproperty
  a_uvlo_stop: assert property (p_uvlo_stop) else $error("no stop below turn-off");

  property p_run_needs_line;
    @(posedge CLK) disable iff (RESET)
      (s_reg.state == ST_PROBE && CYCLE_END && !LINE_ABOVE_RUN && !fault_now && !SUPPLY_BELOW_OFF
       && s_reg.probe_cnt == 2'(`PROBE_CYCLES - 1)) |=> s_reg.state == ST_FAULT && !s_reg.gate;
  endproperty
  a_run_needs_line: assert property (p_run_needs_line) else $error("run entered with low line");

  property p_wait_bias;
    @(posedge CLK) disable iff (RESET)
      (s_reg.state == ST_RUN && DEMAG_DONE && !CYCLE_START && !PEAK_AT_CEILING && !s_reg.cc
       && !fault_now && !SUPPLY_BELOW_OFF && s_reg.ss_cnt != SOFT_SHORT_CYC - 1)
      |=> s_reg.state == ST_WAIT && s_reg.bias == BIAS_WAIT;
  endproperty
  a_wait_bias: assert property (p_wait_bias) else $error("no wait bias after demag");

  property p_fault_restart;
    @(posedge CLK) disable iff (RESET)
      (s_reg.state inside {ST_FAULT, ST_LOCKOUT} && SUPPLY_BELOW_OFF)
      |=> s_reg.state == ST_START && !s_reg.gate && s_reg.bias == BIAS_START;
  endproperty
  a_fault_restart: assert property (p_fault_restart) else $error("no restart after discharge");
endmodule
`default_nettype wire

// file: verification/power_stage_model.sv
// Behavioural flyback power stage seen from the sequencer's cycle inputs.
// Assumes it shares the bench clock and drives only off its falling edge.
`timescale 1ns/100ps
`default_nettype none
module power_stage_model (
  // Clock, gate command and idle gap length
  input  wire logic       clk,
  input  wire logic       gate_on,
  input  wire logic [4:0] period,
  // Switching cycle events
  output var  logic       cycle_start,
  output var  logic       demag_done,
  output var  logic       cycle_end
);
  // ==========================================
  // Switching cycles
  // A stage with its gate off makes no events at all; a cycle once begun
  // still runs to its end, as real magnetics would
  initial
  begin
    cycle_start = 1'b0;
    demag_done  = 1'b0;
    cycle_end   = 1'b0;
    forever
    begin
      @(negedge clk);
      if (gate_on)
      begin
        cycle_start = 1'b1;
        @(negedge clk) cycle_start = 1'b0;
        repeat (3) @(negedge clk);
        demag_done = 1'b1;
        @(negedge clk) demag_done = 1'b0;
        cycle_end = 1'b1;
        @(negedge clk) cycle_end = 1'b0;
        // Idle gap sets the switching rate
        repeat (period) @(negedge clk);
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/flyback_seq_tb.sv
// Self-checking bench for the flyback mode and fault sequencer.
// Assumes short soft-short and hold counts; the power stage is modelled.
`timescale 1ns/100ps
`default_nettype none
module flyback_seq_tb;
  import flyback_seq_pkg::*;
  // ==========================================
  // Shortened counts
  localparam int unsigned SS_CYC = 50;
  localparam int unsigned HOLD   = 80;
  logic        clk, rst, above_on, below_off, line_ok, other_fault, aux_low;
  logic        out_low, out_high, overshoot, at_limit, peak_max, high_load, therm_low;
  logic        cyc_start, demag, cyc_end, gate, probe_pk, raised, cc, latch, smp_low, frc;
  logic [4:0]  period;
  bias_level_t bias;
  seq_state_t  state;
  logic [7:0]  exp_q[$];
  logic [7:0]  cur, prev;
  int          err_count, tests_run;

  flyback_seq #(.SOFT_SHORT_CYC(SS_CYC), .HOLD_CYC(HOLD)) dut (
    .CLK(clk), .RESET(rst), .SUPPLY_ABOVE_ON(above_on), .SUPPLY_BELOW_OFF(below_off),
    .CYCLE_START(cyc_start), .DEMAG_DONE(demag), .CYCLE_END(cyc_end), .LINE_ABOVE_RUN(line_ok),
    .OTHER_FAULT(other_fault), .AUX_BELOW_SOFT_SHORT(aux_low), .OUT_BELOW_REG(out_low),
    .OUT_ABOVE_REG(out_high), .OUT_OVERSHOOT_10PCT(overshoot), .LOAD_AT_LIMIT(at_limit),
    .PEAK_AT_CEILING(peak_max), .HIGH_LOAD(high_load), .THERMAL_PIN_LOW(therm_low),
    .GATE_ENABLE(gate), .PROBE_PEAK_CURRENT(probe_pk), .FORCE_CYCLE(frc), .RAISED_MIN_FREQUENCY(raised),
    .CC_MODE(cc), .SOFT_SHORT_LATCH(latch), .SAMPLED_OUT_LOW(smp_low), .BIAS_LEVEL(bias), .STATE(state));

  power_stage_model stage (.clk(clk), .gate_on(gate), .period(period),
    .cycle_start(cyc_start), .demag_done(demag), .cycle_end(cyc_end));

  // ==========================================
  // Clock, reporting
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic stop_test();
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    tests_run++;
    if (seen !== expv)
    begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, expv);
    end
  endtask

  // ==========================================
  // Watcher: each change of the state snapshot takes the oldest note
  assign cur = {state, bias, gate, probe_pk, latch};
  always @(posedge clk)
  begin
    #1;
    if (!rst && cur !== prev)
      chk(cur, (exp_q.size() != 0) ? exp_q.pop_front() : 8'hFF);
    // Stage cycles far faster than either floor, so no cycle is ever forced
    if (!rst && frc !== 1'b0)
      chk({7'h00, frc}, 8'h00);
    prev = cur;
  end

  // ==========================================
  // Driver tasks
  task automatic push(input seq_state_t s, input bias_level_t b, input logic g, input logic p,
                      input logic l);
    exp_q.push_back({s, b, g, p, l});
  endtask

  // Bounded wait until every note has been matched
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0)
    begin
      @(negedge clk);
      n++;
      if (n > 400)
      begin
        err_count++;
        stop_test();
      end
    end
    repeat (2) @(negedge clk);
  endtask

  // Wait for the next k switching cycles to start, then step off the edge
  task automatic next_cycle(input int k);
    int n;
    repeat (k)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
        if (n > 200)
        begin
          err_count++;
          stop_test();
        end
      end while (cyc_start !== 1'b1);
    end
    @(negedge clk);
  endtask

  task automatic up(input logic ok);
    line_ok = ok;
    period  = 5'(4 + $urandom % 12);
    push(ST_PROBE, BIAS_RUN, 1'b1, 1'b1, 1'b0);
    above_on = 1'b1;
    drain();
    above_on = 1'b0;
    if (ok)
      push(ST_RUN, BIAS_RUN, 1'b1, 1'b0, 1'b0);
    else
      push(ST_FAULT, BIAS_FAULT, 1'b0, 1'b0, 1'b0);
    drain();
  endtask

  task automatic down(input logic l);
    push(ST_START, BIAS_START, 1'b0, 1'b0, l);
    below_off = 1'b1;
    drain();
    below_off = 1'b0;
  endtask

  // three silent restarts, latch clears on the fourth
  task automatic lockouts();
    for (int i = 0; i < 3; i++)
    begin
      down(1'b1);
      push(ST_LOCKOUT, BIAS_FAULT, 1'b0, 1'b0, 1'b1);
      above_on = 1'b1;
      drain();
      above_on = 1'b0;
    end
    down(1'b1);
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    {rst, above_on, below_off, line_ok, other_fault, aux_low, out_low} = 7'h40;
    {out_high, overshoot, at_limit, high_load, therm_low} = 5'h00;
    peak_max = 1'b1;
    period   = 5'h08;
    void'($urandom(57768));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk(cur, 8'h00);
    // Probe with line too low ends in a fault, then the restart
    up(1'b0);
    down(1'b0);
    up(1'b1);
    // wait between cycles below the peak ceiling
    push(ST_WAIT, BIAS_WAIT, 1'b1, 1'b0, 1'b0);
    push(ST_RUN, BIAS_RUN, 1'b1, 1'b0, 1'b0);
    next_cycle(1);
    peak_max = 1'b0;
    next_cycle(1);
    peak_max = 1'b1;
    drain();
    // Raised floor, released by a 10 percent overshoot
    high_load = 1'b1;
    next_cycle(3);
    chk({7'h00, raised}, 8'h01);
    high_load = 1'b0;
    out_high  = 1'b1;
    next_cycle(2);
    chk({7'h00, raised}, 8'h01);
    overshoot = 1'b1;
    next_cycle(2);
    overshoot = 1'b0;
    chk({7'h00, raised}, 8'h00);
    // Raised floor, released by a long stay above regulation
    out_high  = 1'b0;
    high_load = 1'b1;
    next_cycle(3);
    high_load = 1'b0;
    out_high  = 1'b1;
    repeat (HOLD / 2) @(negedge clk);
    chk({7'h00, raised}, 8'h01);
    repeat (HOLD) @(negedge clk);
    next_cycle(2);
    chk({7'h00, raised}, 8'h00);
    out_high = 1'b0;
    // Constant current; a mid-cycle change waits for the cycle end
    out_low  = 1'b1;
    at_limit = 1'b1;
    repeat (2) @(negedge clk);
    chk({7'h00, smp_low}, 8'h00);
    next_cycle(2);
    chk({7'h00, cc}, 8'h01);
    chk({7'h00, smp_low}, 8'h01);
    // Interrupted then sustained soft short
    push(ST_FAULT, BIAS_FAULT, 1'b0, 1'b0, 1'b1);
    aux_low = 1'b1;
    repeat (SS_CYC - 10) @(negedge clk);
    aux_low = 1'b0;
    repeat (5) @(negedge clk);
    aux_low = 1'b1;
    repeat (SS_CYC - 5) @(negedge clk);
    chk(8'(exp_q.size()), 8'h01);
    drain();
    lockouts();
    up(1'b1);
    // Short still present: trips again
    push(ST_FAULT, BIAS_FAULT, 1'b0, 1'b0, 1'b1);
    drain();
    {aux_low, out_low, at_limit} = 3'h0;
    lockouts();
    up(1'b1);
    // Thermal pin pulled low acts as a fault, back in CV after restart
    push(ST_FAULT, BIAS_FAULT, 1'b0, 1'b0, 1'b0);
    therm_low = 1'b1;
    drain();
    therm_low = 1'b0;
    down(1'b0);
    up(1'b1);
    next_cycle(2);
    chk({7'h00, cc}, 8'h00);
    chk({7'h00, smp_low}, 8'h00);
    // Other fault from run
    push(ST_FAULT, BIAS_FAULT, 1'b0, 1'b0, 1'b0);
    other_fault = 1'b1;
    drain();
    other_fault = 1'b0;
    down(1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
